// ### core/fsp_pkg.sv
// constants and types for the flash status and protection block
package fsp_pkg;
  localparam int ADDR_W = 20;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 20'hfffff;
  // status_low bit positions
  localparam int B_LOCK_LO = 7;
  localparam int B_PROT_HI = 6;
  localparam int B_PROT_LO = 2;
  localparam int B_LATCH   = 1;
  localparam int B_BUSY    = 0;
  // status_high bit positions (relative to bit 8)
  localparam int B_ERS_PAUSE = 7;
  localparam int B_INVERT    = 6;
  localparam int B_SEC_HI    = 5;
  localparam int B_SEC_LO    = 3;
  localparam int B_PRG_PAUSE = 2;
  localparam int B_QUAD      = 1;
  localparam int B_LOCK_HI   = 0;
  localparam logic [4:0] PROT_RST = 5'h00;
  localparam logic [2:0] SEC_RST  = 3'h0;
  // operation lengths in cycles, arbitrary stand-ins for array timing
  localparam logic [15:0] T_STATUS_CYC = 16'h0010;
  localparam logic [15:0] T_PROG_CYC   = 16'h0040;
  localparam logic [15:0] T_ERASE_CYC  = 16'h0100;
  typedef enum logic [3:0] {
    FSP_CMD_NONE   = 4'h0,
    FSP_CMD_WRITE_ENABLE_CMD   = 4'h1,
    FSP_CMD_WRITE_DISABLE_CMD   = 4'h2,
    FSP_CMD_STAT   = 4'h3,
    FSP_CMD_PROG   = 4'h4,
    FSP_CMD_SECT   = 4'h5,
    FSP_CMD_BLK32  = 4'h6,
    FSP_CMD_BLK64  = 4'h7,
    FSP_CMD_CHIP   = 4'h8,
    FSP_CMD_SUSP   = 4'h9,
    FSP_CMD_RESUME = 4'ha,
    FSP_CMD_SRESET = 4'hb
  } fsp_cmd_t;
  typedef enum logic [2:0] {
    FSP_IDLE  = 3'b000,
    FSP_STAT  = 3'b001,
    FSP_PROG  = 3'b010,
    FSP_ERASE = 3'b011,
    FSP_PPAUS = 3'b100,
    FSP_EPAUS = 3'b101
  } fsp_state_t;
endpackage : fsp_pkg

// ### core/fsp_range_dec.sv
// protected range decoder from prot field and invert bit
`timescale 1ns/1ns
module fsp_range_dec
  import fsp_pkg::*;
(
  input  wire logic [4:0]        prot_i,
  input  wire logic              invert_i,
  input  wire logic [ADDR_W-1:0] lo_addr_i,
  input  wire logic [ADDR_W-1:0] hi_addr_i,
  output logic                   hit_o
);
  logic              any_d;
  logic [ADDR_W-1:0] base_d;
  logic [ADDR_W-1:0] lim_d;
  logic [ADDR_W-1:0] sz_d;
  logic [2:0]        low3;
  always_comb begin
    low3   = prot_i[2:0];
    any_d  = 1'b0;
    base_d = '0;
    lim_d  = ADDR_TOP;
    sz_d   = '0;
    if (!prot_i[4]) begin
      case (low3)
        3'b001: sz_d = 20'h10000;
        3'b010: sz_d = 20'h20000;
        3'b011: sz_d = 20'h40000;
        3'b100: sz_d = 20'h80000;
        default: sz_d = '0;
      endcase
    end else begin
      case (low3)
        3'b001: sz_d = 20'h01000;
        3'b010: sz_d = 20'h02000;
        3'b011: sz_d = 20'h04000;
        3'b100, 3'b101: sz_d = 20'h08000;
        default: sz_d = '0;
      endcase
    end
    if (low3 == 3'b000) begin
      any_d = invert_i;
    end else if (low3[2:1] == 2'b11) begin
      any_d = ~invert_i;
    end else if (!prot_i[4] && low3 == 3'b101) begin
      any_d = ~invert_i;
    end else if (!invert_i) begin
      any_d = 1'b1;
      if (prot_i[3]) lim_d = sz_d - 20'h1;
      else base_d = ADDR_TOP - sz_d + 20'h1;
    end else begin
      any_d = 1'b1;
      case ({prot_i[4], prot_i[3]})
        2'b00: lim_d = ADDR_TOP - sz_d;
        2'b01: base_d = sz_d;
        2'b10: lim_d = ADDR_TOP - sz_d;
        default: base_d = sz_d;
      endcase
    end
    hit_o = any_d && (hi_addr_i >= base_d) && (lo_addr_i <= lim_d);
  end
endmodule : fsp_range_dec

// ### core/fsp_status.sv
// status register pair, write latch, busy and protection gating
`timescale 1ns/1ns
module fsp_status
  import fsp_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [3:0]        cmd_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [15:0]       wr_data_i,
  output logic [7:0]             status_low_o,
  output logic [7:0]             status_high_o,
  output logic                   cmd_refused_o,
  output logic                   array_go_o,
  output logic                   busy_flag_o,
  output logic                   quad_pins_on_o
);
  fsp_state_t        state_q;
  logic              write_latch_q;
  logic [4:0]        prot_q;
  logic              invert_q;
  logic              lock_lo_q;
  logic              lock_hi_q;
  logic [2:0]        sec_q;
  logic [15:0]       cnt_q;
  logic [15:0]       pend_q;
  logic              refused_q;
  logic              go_q;
  logic [ADDR_W-1:0] lo_a;
  logic [ADDR_W-1:0] hi_a;
  logic              hit;
  fsp_cmd_t          cmd;
  logic              busy;
  logic              accept;
  logic              is_erase;
  logic              is_arr;
  logic              chip_ok;
  logic              sr_ok;
  assign cmd = fsp_cmd_t'(cmd_i);
  function automatic logic [ADDR_W-1:0] span(input fsp_cmd_t c);
    case (c)
      FSP_CMD_SECT:  span = 20'h00fff;
      FSP_CMD_BLK32: span = 20'h07fff;
      FSP_CMD_BLK64: span = 20'h0ffff;
      default:       span = 20'h00000;
    endcase
  endfunction : span
  assign lo_a = cmd_addr_i & ~span(cmd);
  assign hi_a = cmd_addr_i | span(cmd);
  fsp_range_dec u_dec (
    .prot_i    (prot_q),
    .invert_i  (invert_q),
    .lo_addr_i (lo_a),
    .hi_addr_i (hi_a),
    .hit_o     (hit)
  );
  assign busy = (state_q == FSP_STAT) || (state_q == FSP_PROG) ||
                (state_q == FSP_ERASE);
  assign is_erase = (cmd == FSP_CMD_SECT) || (cmd == FSP_CMD_BLK32) ||
                    (cmd == FSP_CMD_BLK64) || (cmd == FSP_CMD_CHIP);
  assign is_arr = is_erase || (cmd == FSP_CMD_PROG);
  assign chip_ok = (prot_q[2:0] == 3'b000 && !invert_q) ||
                   (prot_q[2:0] == 3'b111 && invert_q);
  // any set lock_hi bars status writes
  assign sr_ok = !lock_hi_q;
  always_comb begin
    accept = 1'b0;
    // a parked operation must finish or be dropped by a software reset before another one is taken
    if (cmd_valid_i && state_q == FSP_IDLE && write_latch_q) begin
      if (cmd == FSP_CMD_STAT) accept = sr_ok;
      else if (cmd == FSP_CMD_CHIP) accept = chip_ok;
      else if (is_arr) accept = !hit;
    end
  end
  // the busy state machine; a suspend parks a program or erase, never a status write
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q <= FSP_IDLE;
      cnt_q   <= '0;
      pend_q  <= '0;
    end else if (clk_en_i) begin
      case (state_q)
        FSP_IDLE: begin
          if (accept) begin
            if (cmd == FSP_CMD_STAT) begin
              state_q <= FSP_STAT;
              cnt_q   <= T_STATUS_CYC;
            end else if (cmd == FSP_CMD_PROG) begin
              state_q <= FSP_PROG;
              cnt_q   <= T_PROG_CYC;
            end else begin
              state_q <= FSP_ERASE;
              cnt_q   <= T_ERASE_CYC;
            end
          end
        end
        FSP_STAT, FSP_PROG, FSP_ERASE: begin
          if (cmd_valid_i && cmd == FSP_CMD_SUSP &&
              state_q != FSP_STAT) begin
            pend_q  <= cnt_q;
            state_q <= (state_q == FSP_PROG) ? FSP_PPAUS : FSP_EPAUS;
          end else if (cnt_q <= 16'h0001) begin
            state_q <= FSP_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        FSP_PPAUS, FSP_EPAUS: begin
          if (cmd_valid_i && cmd == FSP_CMD_SRESET) begin
            state_q <= FSP_IDLE;
          end else if (cmd_valid_i && cmd == FSP_CMD_RESUME) begin
            cnt_q   <= pend_q;
            state_q <= (state_q == FSP_PPAUS) ? FSP_PROG : FSP_ERASE;
          end
        end
        default: state_q <= FSP_IDLE;
      endcase
    end
  end
  // write latch
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      write_latch_q <= 1'b0;
    end else if (clk_en_i && cmd_valid_i && !busy) begin
      if (cmd == FSP_CMD_WRITE_ENABLE_CMD) write_latch_q <= 1'b1;
      // refused writes outside busy consume the latch too; a retry needs a new enable
      else if (cmd == FSP_CMD_WRITE_DISABLE_CMD || cmd == FSP_CMD_SRESET ||
               cmd == FSP_CMD_STAT || is_arr) write_latch_q <= 1'b0;
    end
  end
  // non-volatile fields; sys_rst_i stands for the power cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      prot_q    <= PROT_RST;
      invert_q  <= 1'b0;
      lock_lo_q <= 1'b0;
      lock_hi_q <= 1'b0;
      sec_q     <= SEC_RST;
    end else if (clk_en_i && accept && cmd == FSP_CMD_STAT) begin
      prot_q    <= wr_data_i[B_PROT_HI:B_PROT_LO];
      lock_lo_q <= wr_data_i[B_LOCK_LO];
      invert_q  <= wr_data_i[8 + B_INVERT];
      lock_hi_q <= wr_data_i[8 + B_LOCK_HI];
      sec_q     <= sec_q | wr_data_i[8 + B_SEC_HI:8 + B_SEC_LO];
    end
  end
  // per-command answer strobes
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      refused_q <= 1'b0;
      go_q      <= 1'b0;
    end else if (clk_en_i) begin
      go_q      <= accept && is_arr;
      refused_q <= cmd_valid_i && (cmd == FSP_CMD_STAT || is_arr) &&
                   !accept;
    end
  end
  assign status_low_o  = {lock_lo_q, prot_q, write_latch_q, busy};
  assign status_high_o = {state_q == FSP_EPAUS, invert_q, sec_q,
                          state_q == FSP_PPAUS, 1'b1, lock_hi_q};
  assign cmd_refused_o  = refused_q;
  assign array_go_o     = go_q;
  assign busy_flag_o    = busy;
  assign quad_pins_on_o = 1'b1;

  a_quad_const: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    status_high_o[B_QUAD] == 1'b1)
    else $error("quad enable not one");
  a_latch_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !write_latch_q && cmd_valid_i ##1 1'b1 |-> !go_q)
    else $error("array op without latch");
  a_busy_rise: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && accept |=> busy)
    else $error("busy not raised");
  a_refuse_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !busy && cmd_valid_i && is_arr && hit |=> !busy)
    else $error("protected op started");
  a_sec_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ($past(sec_q) & ~sec_q) == 3'h0)
    else $error("security lock cleared");
  a_otp_frozen: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    lock_hi_q |=> lock_hi_q && $stable(prot_q))
    else $error("locked status changed");
  a_chip_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && cmd_valid_i && cmd == FSP_CMD_CHIP && !chip_ok |=>
    cmd_refused_o)
    else $error("chip erase not refused");
  a_latch_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && cmd_valid_i && !busy && cmd == FSP_CMD_WRITE_DISABLE_CMD |=>
    !write_latch_q)
    else $error("latch not cleared");
  a_pause_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && cmd_valid_i && cmd == FSP_CMD_RESUME |=>
    !status_high_o[B_ERS_PAUSE] && !status_high_o[B_PRG_PAUSE])
    else $error("paused flag not cleared");
endmodule : fsp_status

// ### verif/fsp_host_model.sv
// host model: issues one decoded command per call, as a controller would
`timescale 1ns/1ns
module fsp_host_model
  import fsp_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              cmd_refused_i,
  input  wire logic              array_go_i,
  output logic                   cmd_valid_o,
  output logic [3:0]             cmd_o,
  output logic [ADDR_W-1:0]      cmd_addr_o,
  output logic [15:0]            wr_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o       = 4'h0;
    cmd_addr_o  = 20'h00000;
    wr_data_o   = 16'h0000;
  end
  // answer pulses are sampled in the cycle after the taking edge
  task automatic issue(input logic [3:0] c, input logic [ADDR_W-1:0] a,
                       input logic [15:0] d, output logic [1:0] res);
    @(posedge sys_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_o       = c;
    cmd_addr_o  = a;
    wr_data_o   = d;
    @(posedge sys_clk_i);
    #1;
    res         = {cmd_refused_i, array_go_i};
    cmd_valid_o = 1'b0;
    // released fields change so a stale value is never mistaken for data
    cmd_o       = ~c;
    cmd_addr_o  = ~a;
    wr_data_o   = ~d;
  endtask : issue
endmodule : fsp_host_model

// ### verif/tb_flash_status_and_protection.sv
// self-checking bench for the status and protection block
`timescale 1ns/1ns
module tb_flash_status_and_protection;
  import fsp_pkg::*;
  logic              sys_clk_i;
  logic              sys_rst_i;
  logic              clk_en_i;
  logic              cmd_valid_i;
  logic [3:0]        cmd_i;
  logic [ADDR_W-1:0] cmd_addr_i;
  logic [15:0]       wr_data_i;
  logic [7:0]        status_low_o;
  logic [7:0]        status_high_o;
  logic              cmd_refused_o;
  logic              array_go_o;
  logic              busy_flag_o;
  logic              quad_pins_on_o;
  logic [1:0]        res;
  int                bad_count = 0;
  int                samples_checked = 0;
  // command, status_low written, address, expected {refused, go}
  logic [33:0]       rows [11];

  fsp_status fsp_status_inst (
    .sys_clk_i      (sys_clk_i),
    .sys_rst_i      (sys_rst_i),
    .clk_en_i       (clk_en_i),
    .cmd_valid_i    (cmd_valid_i),
    .cmd_i          (cmd_i),
    .cmd_addr_i     (cmd_addr_i),
    .wr_data_i      (wr_data_i),
    .status_low_o   (status_low_o),
    .status_high_o  (status_high_o),
    .cmd_refused_o  (cmd_refused_o),
    .array_go_o     (array_go_o),
    .busy_flag_o    (busy_flag_o),
    .quad_pins_on_o (quad_pins_on_o)
  );
  fsp_host_model fsp_host_model_inst (
    .sys_clk_i     (sys_clk_i),
    .cmd_refused_i (cmd_refused_o),
    .array_go_i    (array_go_o),
    .cmd_valid_o   (cmd_valid_i),
    .cmd_o         (cmd_i),
    .cmd_addr_o    (cmd_addr_i),
    .wr_data_o     (wr_data_i)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input logic [3:0] c, input logic [19:0] a,
                    input logic [15:0] d, input logic [1:0] exp);
    fsp_host_model_inst.issue(c, a, d, res);
    chk({6'h00, res}, {6'h00, exp});
  endtask : op

  // bounded wait; a hang shows up as busy still high
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_flag_o !== 1'b0 && n < 400) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({7'h00, busy_flag_o}, 8'h00);
  endtask : wait_idle

  task automatic wr_stat(input logic [15:0] d);
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    op(FSP_CMD_STAT, 20'h00000, d, 2'b00);
    chk(status_low_o & 8'h03, 8'h01);
    wait_idle();
  endtask : wr_stat

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    sys_rst_i = 1'b1;
    clk_en_i  = 1'b1;
    rows = '{{4'h4, 8'h10, 20'h00100, 2'b10},
             {4'h4, 8'h10, 20'h80000, 2'b01},
             {4'h8, 8'h10, 20'h00000, 2'b10},
             {4'h4, 8'h30, 20'h7ffff, 2'b01},
             {4'h4, 8'h30, 20'h80000, 2'b10},
             {4'h4, 8'h44, 20'hfefff, 2'b10},
             {4'h4, 8'h44, 20'hff000, 2'b01},
             {4'h4, 8'h64, 20'h00fff, 2'b01},
             {4'h4, 8'h64, 20'h01000, 2'b10},
             {4'h4, 8'h00, 20'hfffff, 2'b10},
             {4'h8, 8'h1c, 20'h00000, 2'b01}};
    repeat (20) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk(status_low_o, 8'h00);
    chk(status_high_o, 8'h02);
    chk({7'h00, quad_pins_on_o}, 8'h01);
    op(FSP_CMD_PROG, 20'h00000, 16'h0000, 2'b10);
    chk({7'h00, busy_flag_o}, 8'h00);
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    chk(status_low_o, 8'h02);
    op(FSP_CMD_WRITE_DISABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    chk(status_low_o, 8'h00);
    $display("test latch done");
    // quad written as 0 must still read 1
    wr_stat(16'h4810);
    chk(status_low_o, 8'h10);
    chk(status_high_o, 8'h4a);
    $display("test status write done");
    for (int i = 0; i < 11; i++) begin
      wr_stat({8'h48, rows[i][29:22]});
      chk(status_low_o, rows[i][29:22]);
      op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
      op(rows[i][33:30], rows[i][21:2], 16'h0000, rows[i][1:0]);
      chk({7'h00, busy_flag_o}, {7'h00, rows[i][0]});
      chk({7'h00, status_low_o[1]}, 8'h00);
      wait_idle();
    end
    $display("test protection done");
    // invert 0 with low bits 000 leaves the whole array open
    wr_stat(16'h0800);
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    op(FSP_CMD_SECT, 20'h90000, 16'h0000, 2'b01);
    op(FSP_CMD_SUSP, 20'h00000, 16'h0000, 2'b00);
    chk(status_high_o & 8'h84, 8'h80);
    op(FSP_CMD_RESUME, 20'h00000, 16'h0000, 2'b00);
    chk(status_high_o & 8'h84, 8'h00);
    op(FSP_CMD_SUSP, 20'h00000, 16'h0000, 2'b00);
    op(FSP_CMD_SRESET, 20'h00000, 16'h0000, 2'b00);
    chk(status_high_o & 8'h84, 8'h00);
    wait_idle();
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    op(FSP_CMD_PROG, 20'h00040, 16'h0000, 2'b01);
    op(FSP_CMD_SUSP, 20'h00000, 16'h0000, 2'b00);
    chk(status_high_o & 8'h84, 8'h04);
    op(FSP_CMD_RESUME, 20'h00000, 16'h0000, 2'b00);
    chk(status_high_o & 8'h84, 8'h00);
    wait_idle();
    $display("test suspend done");
    // clearing a set secure lock must not take effect
    wr_stat(16'h0100);
    chk(status_high_o, 8'h0b);
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    op(FSP_CMD_STAT, 20'h00000, 16'h0000, 2'b10);
    chk(status_high_o, 8'h0b);
    chk(status_low_o, 8'h00);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk(status_high_o & 8'h03, 8'h02);
    $display("test lock done");
    // with the enable low a command must leave every flag alone
    clk_en_i = 1'b0;
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    chk(status_low_o, 8'h00);
    clk_en_i = 1'b1;
    op(FSP_CMD_WRITE_ENABLE_CMD, 20'h00000, 16'h0000, 2'b00);
    chk(status_low_o, 8'h02);
    $display("test clock enable done");
    conclude();
  end
endmodule : tb_flash_status_and_protection
